// ===== rtl/ovr_cfg.svh
// Summary of operation
// - Bit 15 of each of the four output level registers enables its channel, and it resets to disabled.
// - Bit 14 of each output level register silences its channel when one, and it resets to zero.
// - Bit 13 applies a new gain at once when zero, or at the next zero crossing or after the wait timeout when one.
// - First-pair level codes stay pending until a one is written to bit 8 of either pair register.
// - Second-pair level codes likewise stay pending until a one is written to bit 8 of either register.
// - The level code in bits 7 to 2 maps 000000 to -57 dB, 111001 to 0 dB and 111111 to +6 dB in 1 dB steps.
// - Bit 10 of the second-pair right register enables the extra inverting amplifier, reset zero.
// - Bit 9 of the second-pair right register steers the gain stage to the driver when one (reset) or inverter.
`ifndef OVR_CFG_SVH
`define OVR_CFG_SVH
`define OVR_IDX_P1L 8'h68
`define OVR_IDX_P1R 8'h69
`define OVR_IDX_P2L 8'h6a
`define OVR_IDX_P2R 8'h6b
`define OVR_BIT_EN 15
`define OVR_BIT_SILENCE 14
`define OVR_BIT_ZC 13
`define OVR_BIT_INV 10
`define OVR_BIT_STEER 9
`define OVR_BIT_COMMIT 8
`define OVR_CODE_HI 7
`define OVR_CODE_LO 2
`define OVR_CODE_RST 6'h39
`define OVR_CODE_0DB 7'sh39
`define OVR_STEER_RST 1'b1
`define OVR_CLK_HZ 25000000
`define OVR_ZC_TIMEOUT_US 10000
`define OVR_ZC_TIMEOUT_CYC ((`OVR_CLK_HZ / 1000000) * `OVR_ZC_TIMEOUT_US)
`define OVR_TMO_W 18
`endif

// ===== rtl/ovr_pkg.sv
package ovr_pkg;
  typedef logic signed [6:0] ovr_db_t;
  typedef enum logic [0:0] {
    OVR_IDLE = 1'b0,
    OVR_WAIT = 1'b1
  } ovr_gate_e;
  typedef struct packed {
    logic en;
    logic silence;
    logic zc_gate;
    logic [5:0] code;
  } ovr_chan_s;
endpackage

// ===== rtl/ovr_chan_if.sv
`timescale 1ns/10ps
`default_nettype none
interface ovr_chan_if;
  logic [5:0] written_code;
  logic commit;
  logic zc_gate;
  logic zero_cross;
  logic [5:0] applied_code;
  logic pending;
  modport ctrl (output written_code, output commit, output zc_gate, output zero_cross,
                input applied_code, input pending);
  modport gate (input written_code, input commit, input zc_gate, input zero_cross,
                output applied_code, output pending);
endinterface
`default_nettype wire

// ===== rtl/ovr_gain_gate.sv
`timescale 1ns/10ps
`default_nettype none
`include "ovr_cfg.svh"
module ovr_gain_gate #(
  parameter logic [`OVR_TMO_W-1:0] TIMEOUT_CYC = `OVR_TMO_W'(`OVR_ZC_TIMEOUT_CYC)
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  ovr_chan_if.gate ch
);
  import ovr_pkg::*;
  typedef struct packed {
    ovr_gate_e st;
    logic [5:0] target;
    logic [5:0] applied;
    logic [`OVR_TMO_W-1:0] cnt;
  } ovr_gate_s;
  ovr_gate_s q, next_q;
  logic [5:0] tgt;

  always_comb begin
    next_q = q;
    tgt = ch.commit ? ch.written_code : q.target;
    case (q.st)
      OVR_IDLE: begin
        if (ch.commit) begin
          next_q.target = ch.written_code;
          next_q.cnt = '0;
          if (!ch.zc_gate || ch.zero_cross) begin
            next_q.applied = ch.written_code;
          end else begin
            next_q.st = OVR_WAIT;
          end
        end
      end
      OVR_WAIT: begin
        next_q.target = tgt;
        next_q.cnt = `OVR_TMO_W'(q.cnt + 1'b1);
        // bounded wait so a silent signal cannot stall a change forever
        if (!ch.zc_gate || ch.zero_cross || q.cnt >= TIMEOUT_CYC - 1'b1) begin
          next_q.applied = tgt;
          next_q.st = OVR_IDLE;
        end
      end
      default: begin
        next_q.st = OVR_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '{st: OVR_IDLE, target: `OVR_CODE_RST, applied: `OVR_CODE_RST, cnt: '0};
    end else begin
      q <= next_q;
    end
  end

  assign ch.applied_code = q.applied;
  assign ch.pending = (q.st == OVR_WAIT);

  property p_gate_timeout;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (q.st == OVR_WAIT) |-> (q.cnt < TIMEOUT_CYC);
  endproperty
  a_gate_timeout: assert property (p_gate_timeout) else $error("gated change held past timeout");
  property p_gate_now;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (ch.commit && !ch.zc_gate) |=> (ch.applied_code == $past(ch.written_code)) && !ch.pending;
  endproperty
  a_gate_now: assert property (p_gate_now) else $error("ungated gain not applied at once");
  property p_gate_hold;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (q.st == OVR_WAIT && !ch.commit && ch.zc_gate && !ch.zero_cross && q.cnt < TIMEOUT_CYC - 1'b1)
      |=> $stable(ch.applied_code);
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("gated gain changed before zero cross");
endmodule
`default_nettype wire

// ===== rtl/ovr_output_level_regs.sv
// Implementation choice: the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
`include "ovr_cfg.svh"
module ovr_output_level_regs #(
  parameter logic [`OVR_TMO_W-1:0] ZC_TIMEOUT_CYC = `OVR_TMO_W'(`OVR_ZC_TIMEOUT_CYC)
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [3:0] zero_cross_i,
  output logic [3:0] chan_enable_o,
  output logic [3:0] chan_silence_o,
  output logic [23:0] level_code_o,
  output var ovr_pkg::ovr_db_t [3:0] level_db_o,
  output logic [3:0] level_pending_o,
  output logic inverter_enable_o,
  output logic inverter_steer_o
);
  import ovr_pkg::*;

  typedef struct packed {
    ovr_chan_s [3:0] chan;
    logic inv_en;
    logic steer;
    logic [1:0] commit;
    logic ack;
    logic [31:0] rdat;
    logic [3:0] zc_s1;
    logic [3:0] zc_s2;
    ovr_db_t [3:0] db;
  } ovr_regs_s;

  ovr_regs_s q, next_q;
  logic [5:0] applied [4];
  logic [3:0] pending;
  logic req;
  logic hit;
  logic [1:0] sel_ch;
  logic [7:0] idx;

  ovr_chan_if ch [4] ();

  assign req = wb_cyc_i && wb_stb_i && !q.ack;
  assign idx = wb_adr_i[9:2];

  always_comb begin
    hit = 1'b1;
    sel_ch = 2'd0;
    case (idx)
      `OVR_IDX_P1L: sel_ch = 2'd0;
      `OVR_IDX_P1R: sel_ch = 2'd1;
      `OVR_IDX_P2L: sel_ch = 2'd2;
      `OVR_IDX_P2R: sel_ch = 2'd3;
      default: hit = 1'b0;
    endcase
  end

  always_comb begin
    next_q = q;
    next_q.commit = 2'b00;
    next_q.zc_s1 = zero_cross_i;
    next_q.zc_s2 = q.zc_s1;
    for (int i = 0; i < 4; i++) begin
      next_q.db[i] = ovr_db_t'({1'b0, applied[i]}) - `OVR_CODE_0DB;
    end
    next_q.ack = req;
    if (req) begin
      // unmapped words answer with ack and zero data
      next_q.rdat = 32'h0000_0000;
      if (hit) begin
        next_q.rdat[`OVR_BIT_EN] = q.chan[sel_ch].en;
        next_q.rdat[`OVR_BIT_SILENCE] = q.chan[sel_ch].silence;
        next_q.rdat[`OVR_BIT_ZC] = q.chan[sel_ch].zc_gate;
        // pending code reads back, the commit bit reads zero
        next_q.rdat[`OVR_CODE_HI:`OVR_CODE_LO] = q.chan[sel_ch].code;
        if (sel_ch == 2'd3) begin
          next_q.rdat[`OVR_BIT_INV] = q.inv_en;
          next_q.rdat[`OVR_BIT_STEER] = q.steer;
        end
      end
      if (wb_we_i && hit) begin
        if (wb_sel_i[1]) begin
          next_q.chan[sel_ch].en = wb_dat_i[`OVR_BIT_EN];
          next_q.chan[sel_ch].silence = wb_dat_i[`OVR_BIT_SILENCE];
          next_q.chan[sel_ch].zc_gate = wb_dat_i[`OVR_BIT_ZC];
          if (sel_ch == 2'd3) begin
            next_q.inv_en = wb_dat_i[`OVR_BIT_INV];
            next_q.steer = wb_dat_i[`OVR_BIT_STEER];
          end
          // either register of a pair commits both codes of that pair
          next_q.commit[sel_ch[1]] = wb_dat_i[`OVR_BIT_COMMIT];
        end
        if (wb_sel_i[0]) begin
          next_q.chan[sel_ch].code = wb_dat_i[`OVR_CODE_HI:`OVR_CODE_LO];
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 4; i++) begin
        q.chan[i] <= '{en: 1'b0, silence: 1'b0, zc_gate: 1'b0, code: `OVR_CODE_RST};
        q.db[i] <= ovr_db_t'(0);
      end
      q.inv_en <= 1'b0;
      q.steer <= `OVR_STEER_RST;
      q.commit <= 2'b00;
      q.ack <= 1'b0;
      q.rdat <= 32'h0000_0000;
      q.zc_s1 <= 4'h0;
      q.zc_s2 <= 4'h0;
    end else begin
      q <= next_q;
    end
  end

  for (genvar g = 0; g < 4; g++) begin : g_chan
    assign ch[g].written_code = q.chan[g].code;
    assign ch[g].commit = q.commit[g / 2];
    assign ch[g].zc_gate = q.chan[g].zc_gate;
    assign ch[g].zero_cross = q.zc_s2[g];
    assign applied[g] = ch[g].applied_code;
    assign pending[g] = ch[g].pending;
    assign level_code_o[6*g +: 6] = applied[g];
    assign chan_enable_o[g] = q.chan[g].en;
    assign chan_silence_o[g] = q.chan[g].silence;

    ovr_gain_gate #(
      .TIMEOUT_CYC(ZC_TIMEOUT_CYC)
    ) u_gate (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .ch(ch[g])
    );
  end

  assign level_db_o = q.db;
  assign level_pending_o = pending;
  assign inverter_enable_o = q.inv_en;
  assign inverter_steer_o = q.steer;
  assign wb_dat_o = q.rdat;
  assign wb_ack_o = q.ack;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_wr(logic [7:0] r);
    req && wb_we_i && idx == r && wb_sel_i[1];
  endsequence

  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held longer than one cycle");

  property p_ack_answer;
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("request not answered next cycle");

  property p_enable;
    s_wr(`OVR_IDX_P1L) |=> chan_enable_o[0] == $past(wb_dat_i[`OVR_BIT_EN]);
  endproperty
  a_enable: assert property (p_enable) else $error("enable bit not taken");

  property p_silence;
    s_wr(`OVR_IDX_P2R) |=> chan_silence_o[3] == $past(wb_dat_i[`OVR_BIT_SILENCE]);
  endproperty
  a_silence: assert property (p_silence) else $error("silence bit not taken");

  property p_zc_field;
    s_wr(`OVR_IDX_P1R) |=> q.chan[1].zc_gate == $past(wb_dat_i[`OVR_BIT_ZC]);
  endproperty
  a_zc_field: assert property (p_zc_field) else $error("zero-cross gate bit not taken");

  property p_pair1_commit;
    (s_wr(`OVR_IDX_P1R) ##0 wb_dat_i[`OVR_BIT_COMMIT]) |=> q.commit[0] && !q.commit[1];
  endproperty
  a_pair1_commit: assert property (p_pair1_commit) else $error("pair one commit not raised");

  property p_pair1_hold;
    (!q.commit[0] && !pending[0] && !pending[1]) |=> $stable(level_code_o[11:0]);
  endproperty
  a_pair1_hold: assert property (p_pair1_hold) else $error("pair one code moved without commit");

  property p_pair2_both;
    (s_wr(`OVR_IDX_P2L) ##0 wb_sel_i[0] && wb_dat_i[`OVR_BIT_COMMIT] && !wb_dat_i[`OVR_BIT_ZC]
      && !q.chan[3].zc_gate)
      |=> ##1 level_code_o[17:12] == $past(wb_dat_i[7:2], 2) && level_code_o[23:18] == $past(q.chan[3].code, 2);
  endproperty
  a_pair2_both: assert property (p_pair2_both) else $error("pair two codes not applied together");

  property p_db_map;
    1'b1 |=> level_db_o[0] == ovr_db_t'({1'b0, $past(level_code_o[5:0])}) - `OVR_CODE_0DB;
  endproperty
  a_db_map: assert property (p_db_map) else $error("level code to dB map wrong");

  property p_inverter;
    s_wr(`OVR_IDX_P2R) |=> inverter_enable_o == $past(wb_dat_i[`OVR_BIT_INV])
      && inverter_steer_o == $past(wb_dat_i[`OVR_BIT_STEER]);
  endproperty
  a_inverter: assert property (p_inverter) else $error("inverter bits not taken");

  property p_readback;
    (req && !wb_we_i && idx == `OVR_IDX_P1L) |=> wb_dat_o[7:2] == $past(q.chan[0].code)
      && !wb_dat_o[`OVR_BIT_COMMIT] && wb_dat_o[`OVR_BIT_EN] == $past(chan_enable_o[0]);
  endproperty
  a_readback: assert property (p_readback) else $error("readback differs from written value");

  sequence s_rd(logic [7:0] r);
    req && !wb_we_i && idx == r;
  endsequence

  sequence s_code_wr(logic [7:0] r);
    req && wb_we_i && idx == r && wb_sel_i[0];
  endsequence

  sequence s_commit(logic [7:0] r);
    s_wr(r) ##0 wb_dat_i[`OVR_BIT_COMMIT];
  endsequence

  property p_enable_p1r;
    s_wr(`OVR_IDX_P1R) |=> chan_enable_o[1] == $past(wb_dat_i[`OVR_BIT_EN]);
  endproperty
  a_enable_p1r: assert property (p_enable_p1r) else $error("pair one right enable not taken");

  property p_enable_p2r;
    s_wr(`OVR_IDX_P2R) |=> chan_enable_o[3] == $past(wb_dat_i[`OVR_BIT_EN]);
  endproperty
  a_enable_p2r: assert property (p_enable_p2r) else $error("pair two right enable not taken");

  property p_silence_p1l;
    s_wr(`OVR_IDX_P1L) |=> chan_silence_o[0] == $past(wb_dat_i[`OVR_BIT_SILENCE]);
  endproperty
  a_silence_p1l: assert property (p_silence_p1l) else $error("pair one left silence not taken");

  property p_silence_p1r;
    s_wr(`OVR_IDX_P1R) |=> chan_silence_o[1] == $past(wb_dat_i[`OVR_BIT_SILENCE]);
  endproperty
  a_silence_p1r: assert property (p_silence_p1r) else $error("pair one right silence not taken");

  property p_zc_p1l;
    s_wr(`OVR_IDX_P1L) |=> q.chan[0].zc_gate == $past(wb_dat_i[`OVR_BIT_ZC]);
  endproperty
  a_zc_p1l: assert property (p_zc_p1l) else $error("pair one left gate bit not taken");

  property p_zc_p2r;
    s_wr(`OVR_IDX_P2R) |=> q.chan[3].zc_gate == $past(wb_dat_i[`OVR_BIT_ZC]);
  endproperty
  a_zc_p2r: assert property (p_zc_p2r) else $error("pair two right gate bit not taken");

  property p_pair1_commit_l;
    s_commit(`OVR_IDX_P1L) |=> q.commit[0] && !q.commit[1];
  endproperty
  a_pair1_commit_l: assert property (p_pair1_commit_l) else $error("pair one commit from left missing");

  property p_pair2_commit_l;
    s_commit(`OVR_IDX_P2L) |=> q.commit[1] && !q.commit[0];
  endproperty
  a_pair2_commit_l: assert property (p_pair2_commit_l) else $error("pair two commit from left missing");

  property p_pair2_commit_r;
    s_commit(`OVR_IDX_P2R) |=> q.commit[1] && !q.commit[0];
  endproperty
  a_pair2_commit_r: assert property (p_pair2_commit_r) else $error("pair two commit from right missing");

  property p_pair2_hold;
    (!q.commit[1] && !pending[2] && !pending[3]) |=> $stable(level_code_o[23:12]);
  endproperty
  a_pair2_hold: assert property (p_pair2_hold) else $error("pair two code moved without commit");

  property p_pair1_both;
    (s_commit(`OVR_IDX_P1R) ##0 wb_sel_i[0] && !wb_dat_i[`OVR_BIT_ZC] && !q.chan[0].zc_gate)
      |=> ##1 level_code_o[11:6] == $past(wb_dat_i[7:2], 2)
      && level_code_o[5:0] == $past(q.chan[0].code, 2);
  endproperty
  a_pair1_both: assert property (p_pair1_both) else $error("pair one codes not applied together");

  property p_db_floor;
    (level_code_o[5:0] == 6'h00) |=> level_db_o[0] == -7'sh39;
  endproperty
  a_db_floor: assert property (p_db_floor) else $error("lowest code not at floor level");

  property p_db_unity;
    (level_code_o[23:18] == 6'h39) |=> level_db_o[3] == 7'sh00;
  endproperty
  a_db_unity: assert property (p_db_unity) else $error("unity code not at zero level");

  property p_db_top;
    (level_code_o[11:6] == 6'h3f) |=> level_db_o[1] == 7'sh06;
  endproperty
  a_db_top: assert property (p_db_top) else $error("highest code not at top level");

  property p_readback_p2r;
    s_rd(`OVR_IDX_P2R) |=> wb_dat_o[7:2] == $past(q.chan[3].code) && !wb_dat_o[`OVR_BIT_COMMIT]
      && wb_dat_o[`OVR_BIT_INV] == $past(inverter_enable_o)
      && wb_dat_o[`OVR_BIT_STEER] == $past(inverter_steer_o);
  endproperty
  a_readback_p2r: assert property (p_readback_p2r) else $error("pair two right readback wrong");

  property p_unused_bits;
    wb_ack_o |-> (wb_dat_o & 32'hffff_1903) == 32'h0000_0000;
  endproperty
  a_unused_bits: assert property (p_unused_bits) else $error("unused or strobe bits read nonzero");

  property p_unmapped;
    (req && !hit) |=> wb_dat_o == 32'h0000_0000 && q.chan == $past(q.chan) && q.commit == 2'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access had an effect");

  property p_inv_only_p2r;
    (req && wb_we_i && idx != `OVR_IDX_P2R) |=> $stable(inverter_enable_o) && $stable(inverter_steer_o);
  endproperty
  a_inv_only_p2r: assert property (p_inv_only_p2r) else $error("inverter bits moved by other word");

  property p_lane1_gate;
    (req && wb_we_i && !wb_sel_i[1]) |=> $stable(chan_enable_o) && $stable(chan_silence_o)
      && q.commit == 2'h0;
  endproperty
  a_lane1_gate: assert property (p_lane1_gate) else $error("control bits taken with lane off");

  property p_code_p1l;
    s_code_wr(`OVR_IDX_P1L) |=> q.chan[0].code == $past(wb_dat_i[`OVR_CODE_HI:`OVR_CODE_LO]);
  endproperty
  a_code_p1l: assert property (p_code_p1l) else $error("written code not held for readback");

  property p_commit_strobe;
    (q.commit != 2'h0) |=> q.commit == 2'h0;
  endproperty
  a_commit_strobe: assert property (p_commit_strobe) else $error("commit held longer than one cycle");

  property p_zc_sync;
    1'b1 |=> q.zc_s1 == $past(zero_cross_i) && q.zc_s2 == $past(q.zc_s1);
  endproperty
  a_zc_sync: assert property (p_zc_sync) else $error("zero-cross synchroniser skipped a stage");

  property p_pend_rise1;
    $rose(level_pending_o[0]) |-> $past(q.commit[0]);
  endproperty
  a_pend_rise1: assert property (p_pend_rise1) else $error("pair one wait began without commit");

  property p_pend_rise2;
    $rose(level_pending_o[3]) |-> $past(q.commit[1]);
  endproperty
  a_pend_rise2: assert property (p_pend_rise2) else $error("pair two wait began without commit");

  property p_pend_release;
    (level_pending_o[0] && !q.chan[0].zc_gate) |=> !level_pending_o[0];
  endproperty
  a_pend_release: assert property (p_pend_release) else $error("cleared gate kept change waiting");
endmodule
`default_nettype wire

// ===== verif/tb_ovr_output_level_regs.sv
`timescale 1ns/10ps
`default_nettype none
module tb_ovr_output_level_regs;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic [3:0] zc = 4'h0;
  logic [3:0] chan_en;
  logic [3:0] chan_sil;
  logic [23:0] codes;
  ovr_pkg::ovr_db_t [3:0] db;
  logic [3:0] pend;
  logic inv_en;
  logic inv_steer;
  logic [3:0] lane = 4'h3;
  int fail_count = 0;
  int n_compared = 0;

  // short timeout keeps the gated-change wait inside a few dozen cycles
  ovr_output_level_regs #(.ZC_TIMEOUT_CYC(18'd20)) i_ovr_output_level_regs (
    .core_clk_i(core_clk), .rst_n_i(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .zero_cross_i(zc), .chan_enable_o(chan_en), .chan_silence_o(chan_sil), .level_code_o(codes),
    .level_db_o(db), .level_pending_o(pend), .inverter_enable_o(inv_en), .inverter_steer_o(inv_steer)
  );

  always #20 core_clk = ~core_clk;

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // ack is read at the edge itself, so the value seen is the one the edge sampled
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [15:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= lane;
    wdat <= {16'h0000, d};
    do begin
      @(posedge core_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      chk(32'h0, 32'h1);
    end
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    logic [31:0] dummy;
    xfer(1'b1, idx, d, dummy);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    xfer(1'b0, idx, 16'h0000, r);
    chk(r, exp);
  endtask

  task automatic ticks(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  initial begin
    ticks(5000);
    fail_count++;
    end_sim();
  end

  initial begin
    ticks(8);
    rst_n <= 1'b1;
    rd_chk(8'h68, 32'h0000_00e4);
    rd_chk(8'h6a, 32'h0000_00e4);
    rd_chk(8'h6b, 32'h0000_02e4);
    chk({28'h0, chan_en}, 32'h0);
    chk({28'h0, chan_sil}, 32'h0);
    chk({30'h0, inv_en, inv_steer}, 32'h1);
    chk({8'h0, codes}, {8'h0, 6'h39, 6'h39, 6'h39, 6'h39});
    // pending code with no commit must not reach the outputs
    wr(8'h68, 16'hc000);
    ticks(3);
    rd_chk(8'h68, 32'h0000_c000);
    chk({24'h0, chan_en, chan_sil}, 32'h11);
    chk({26'h0, codes[5:0]}, 32'h39);
    wr(8'h69, 16'h01fc);
    ticks(3);
    chk({8'h0, codes}, {8'h0, 6'h39, 6'h39, 6'h3f, 6'h00});
    chk({25'h0, db[0]}, {25'h0, 7'h47});
    chk({25'h0, db[1]}, {25'h0, 7'h06});
    rd_chk(8'h69, 32'h0000_00fc);
    wr(8'h6a, 16'h0014);
    ticks(3);
    chk({26'h0, codes[17:12]}, 32'h39);
    wr(8'h6b, 16'h8540);
    ticks(3);
    chk({8'h0, codes}, {8'h0, 6'h10, 6'h05, 6'h3f, 6'h00});
    chk({30'h0, inv_en, inv_steer}, 32'h2);
    chk({28'h0, chan_en}, 32'h9);
    rd_chk(8'h6b, 32'h0000_8440);
    rd_chk(8'h6c, 32'h0);
    // gated change held until the crossing arrives
    wr(8'h68, 16'h2180);
    ticks(2);
    chk({28'h0, pend}, 32'h1);
    chk({26'h0, codes[5:0]}, 32'h00);
    chk({28'h0, chan_en}, 32'h8);
    zc <= 4'h1;
    ticks(6);
    zc <= 4'h0;
    chk({26'h0, codes[5:0]}, 32'h20);
    chk({28'h0, pend}, 32'h0);
    // no crossing at all: timeout must release the change
    wr(8'h68, 16'h2184);
    ticks(12);
    chk({28'h0, pend}, 32'h1);
    chk({26'h0, codes[5:0]}, 32'h20);
    ticks(20);
    chk({26'h0, codes[5:0]}, 32'h21);
    chk({28'h0, pend}, 32'h0);
    // code lane alone: control bits and commit must be ignored
    lane = 4'h1;
    wr(8'h69, 16'hc100);
    lane = 4'h3;
    rd_chk(8'h69, 32'h0000_0000);
    chk({26'h0, codes[11:6]}, 32'h3f);
    chk({28'h0, chan_sil}, 32'h0);
    // pair two commit through control lane only, right side gated
    wr(8'h6a, 16'h0028);
    wr(8'h6b, 16'h8460);
    lane = 4'h2;
    wr(8'h6b, 16'ha3ff);
    lane = 4'h3;
    ticks(2);
    chk({28'h0, pend}, 32'h8);
    chk({20'h0, codes[23:12]}, {20'h0, 6'h10, 6'h0a});
    chk({30'h0, inv_en, inv_steer}, 32'h1);
    rd_chk(8'h6b, 32'h0000_a260);
    zc <= 4'h8;
    ticks(6);
    zc <= 4'h0;
    chk({26'h0, codes[23:18]}, 32'h18);
    chk({28'h0, pend}, 32'h0);
    // second reset in mid-run restores every field
    rst_n <= 1'b0;
    ticks(2);
    rst_n <= 1'b1;
    rd_chk(8'h6b, 32'h0000_02e4);
    chk({8'h0, codes}, {8'h0, 6'h39, 6'h39, 6'h39, 6'h39});
    chk({24'h0, chan_en, chan_sil}, 32'h0);
    chk({28'h0, pend}, 32'h0);
    chk({30'h0, inv_en, inv_steer}, 32'h1);
    chk({25'h0, db[3]}, 32'h0);
    end_sim();
  end
endmodule
`default_nettype wire
